// ### logic/tcc_pkg.sv
// constants shared by the timer channel capture/compare block
package tcc_pkg;
    localparam int         NCH        = 4;
    // register byte addresses
    localparam logic [7:0] OFF_CTRL0  = 8'h00;
    localparam logic [7:0] OFF_VALH0  = 8'h10;
    localparam logic [7:0] OFF_VALL0  = 8'h20;
    localparam logic [7:0] OFF_TCTL   = 8'h30;
    localparam logic [7:0] OFF_MOD    = 8'h34;
    localparam logic [7:0] OFF_CNT    = 8'h38;
    localparam int         REG_STRIDE = 4;
    // channel control/status bit positions
    localparam int         CB_FLAG    = 7;
    localparam int         CB_IE      = 6;
    localparam int         CB_MSB     = 5;
    localparam int         CB_MSA     = 4;
    localparam int         CB_ELSB    = 3;
    localparam int         CB_ELSA    = 2;
    localparam int         CB_TOV     = 1;
    localparam int         CB_MAX     = 0;
    // timer control bit positions
    localparam int         TB_STOP    = 5;
    localparam int         TB_RST     = 4;
    localparam int         TB_PS      = 0;
    // values after reset
    localparam logic       STOP_RST   = 1'b1;
    localparam logic [15:0] MOD_RST   = 16'hffff;
    localparam logic [2:0] PS_RST     = 3'h0;
    // edge/level codes
    localparam logic [1:0] ELS_OFF    = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_LOW    = 2'h2;
    localparam logic [1:0] ELS_HIGH   = 2'h3;
    // largest prescaler code, higher codes clamp to it
    localparam logic [2:0] PS_MAX     = 3'h6;
endpackage : tcc_pkg

// ### logic/tcc_counter.sv
// 16-bit modulo counter with prescaler, clear and stop
`timescale 1ns/100ps
module tcc_counter (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        stop_in,
    input  wire logic        clr_in,
    input  wire logic [2:0]  ps_in,
    input  wire logic [15:0] mod_in,
    output logic      [15:0] cnt_out,
    output logic             step_out,
    output logic             ovf_out
);
    typedef struct packed {
        logic [5:0]  pre;
        logic [15:0] cnt;
        logic        step;
        logic        ovf;
    } tcc_cnt_s;

    tcc_cnt_s q;
    tcc_cnt_s d;

    always_comb begin
        logic [2:0] ps;
        logic [6:0] mask;
        ps   = (ps_in > tcc_pkg::PS_MAX) ? tcc_pkg::PS_MAX : ps_in;
        mask = (7'h01 << ps) - 7'h01;
        d        = q;
        d.step   = 1'b0;
        d.ovf    = 1'b0;
        if (clr_in) begin
            d.pre = 6'h00;
            d.cnt = 16'h0000;
        end else if (!stop_in) begin
            if ((q.pre & mask[5:0]) == mask[5:0]) begin
                d.pre  = 6'h00;
                d.step = 1'b1;
                if (q.cnt == mod_in) begin
                    d.cnt = 16'h0000;
                    d.ovf = 1'b1;
                end else begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end else begin
                d.pre = q.pre + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt_out  = q.cnt;
    assign step_out = q.step;
    assign ovf_out  = q.ovf;
endmodule : tcc_counter

// ### logic/tcc_timer_channels.sv
// four-channel capture, compare and pwm logic with apb registers
`timescale 1ns/100ps
//
// Function
// - capture edge sets the channel flag
// - counter equal to value sets flag
// - read-set then write-zero clears; new event wins
// - writing one keeps flag; reset clears it
// - interrupt request while enable and flag set
// - pair buffered bit disables odd channel, frees pin
// - mode bit picks capture or unbuffered compare
// - edge field zero: mode bit presets level
// - edge field zero releases pin to port
// - capture edge: rising, falling or both
// - compare action: toggle, low or high
// - buffered bit forces buffered compare/pwm mode
// - toggle-on-overflow toggles output each overflow
// - overflow action beats same-cycle compare action
// - max-duty bit forces full-duty pwm output while toggle-on-overflow is clear
// - max-duty change applies from next period
// - value register holds capture or compare value
// - high byte read blocks capture until low
// - high byte write blocks compare until low
// - counter overflows at modulo, restarts at zero
// - counter reset clears counter and prescaler only
module tcc_timer_channels (
    input  wire logic        MCLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic [3:0]  CH_PIN_IN,
    output logic      [3:0]  CH_PIN_OUT,
    output logic      [3:0]  CH_PIN_OE_OUT,
    output logic      [3:0]  CH_IRQ_OUT
);
    typedef struct packed {
        logic [3:0]       flag;
        logic [3:0]       ie;
        logic [3:0]       msb;
        logic [3:0]       msa;
        logic [3:0][1:0]  els;
        logic [3:0]       tov;
        logic [3:0]       mx;
        logic [3:0]       mx_eff;
        logic [3:0]       armed;
        logic [3:0]       cap_lock;
        logic [3:0]       cmp_lock;
        logic [3:0]       s1;
        logic [3:0]       s2;
        logic [3:0]       prev;
        logic [3:0]       out;
        logic [3:0]       oe;
        logic [3:0]       irq;
        logic [3:0][15:0] val;
        logic [1:0]       bsel;
        logic             counter_stop_bit;
        logic             trst;
        logic [2:0]       ps;
        logic [15:0]      modulo;
        logic             ready;
        logic             slverr;
        logic [31:0]      rdata;
    } tcc_state_s;

    tcc_state_s  q;
    tcc_state_s  d;
    logic [15:0] ccnt;
    logic        cstep;
    logic        covf;

    tcc_counter u_counter (
        .clk_in   (MCLK_IN),
        .rst_in   (SYS_RST_IN),
        .stop_in  (q.counter_stop_bit),
        .clr_in   (q.trst),
        .ps_in    (q.ps),
        .mod_in   (q.modulo),
        .cnt_out  (ccnt),
        .step_out (cstep),
        .ovf_out  (covf)
    );

    always_comb begin
        logic        acc;
        logic        done;
        logic        w_en;
        logic        r_en;
        logic        hit_t;
        logic        hit_m;
        logic        hit_n;
        logic        any;
        logic [3:0]  dis;
        logic [3:0]  bufm;
        logic [3:0]  act;
        logic [3:0]  capm;
        logic [3:0]  cmpm;
        logic [3:0]  msnz;
        logic [3:0]  hit_c;
        logic [3:0]  hit_h;
        logic [3:0]  hit_l;
        logic [3:0]  ev;
        logic [3:0]  ev_cap;
        logic [3:0]  match;
        logic [31:0] rd;
        logic [7:0]  w;
        int          src;
        acc    = PSEL_IN & PENABLE_IN;
        done   = acc & q.ready;
        w_en   = done & PWRITE_IN;
        r_en   = done & ~PWRITE_IN;
        w      = PWDATA_IN[7:0];
        hit_t  = (PADDR_IN == tcc_pkg::OFF_TCTL);
        hit_m  = (PADDR_IN == tcc_pkg::OFF_MOD);
        hit_n  = (PADDR_IN == tcc_pkg::OFF_CNT);
        dis    = '0;
        bufm   = '0;
        act    = '0;
        capm   = '0;
        cmpm   = '0;
        msnz   = '0;
        hit_c  = '0;
        hit_h  = '0;
        hit_l  = '0;
        ev     = '0;
        ev_cap = '0;
        match  = '0;
        rd     = '0;
        src    = 0;
        d      = q;

        // mode decode and address decode per channel
        for (int i = 0; i < tcc_pkg::NCH; i++) begin
            dis[i]   = (i % 2 == 1) && q.msb[i & 2];
            bufm[i]  = (i % 2 == 0) && q.msb[i];
            act[i]   = (q.els[i] != tcc_pkg::ELS_OFF) && !dis[i];
            capm[i]  = act[i] & ~bufm[i] & ~q.msa[i];
            cmpm[i]  = act[i] & (bufm[i] | q.msa[i]);
            msnz[i]  = q.msa[i] | q.msb[i & 2];
            hit_c[i] = PADDR_IN == tcc_pkg::OFF_CTRL0 + 8'(i * tcc_pkg::REG_STRIDE);
            hit_h[i] = PADDR_IN == tcc_pkg::OFF_VALH0 + 8'(i * tcc_pkg::REG_STRIDE);
            hit_l[i] = PADDR_IN == tcc_pkg::OFF_VALL0 + 8'(i * tcc_pkg::REG_STRIDE);
            if (hit_c[i] && !dis[i]) begin
                rd[7:0] = {q.flag[i], q.ie[i], bufm[i], q.msa[i], q.els[i], q.tov[i], q.mx[i]};
            end
            if (hit_h[i]) begin
                rd[7:0] = q.val[i][15:8];
            end
            if (hit_l[i]) begin
                rd[7:0] = q.val[i][7:0];
            end
        end
        if (hit_t) begin
            rd[7:0] = {2'h0, q.counter_stop_bit, 1'b0, 1'b0, q.ps};
        end
        if (hit_m) begin
            rd[15:0] = q.modulo;
        end
        if (hit_n) begin
            rd[15:0] = ccnt;
        end
        any = (|hit_c) | (|hit_h) | (|hit_l) | hit_t | hit_m | hit_n;

        // apb answer one cycle into the access phase
        d.ready  = acc & ~q.ready;
        d.slverr = acc & ~q.ready & ~any;
        d.rdata  = (acc & ~q.ready) ? rd : 32'h0000_0000;
        d.trst   = 1'b0;

        // register writes
        if (w_en) begin
            for (int i = 0; i < tcc_pkg::NCH; i++) begin
                if (hit_c[i] && !dis[i]) begin
                    d.ie[i]  = w[tcc_pkg::CB_IE];
                    d.msa[i] = w[tcc_pkg::CB_MSA];
                    d.els[i] = w[tcc_pkg::CB_ELSB:tcc_pkg::CB_ELSA];
                    d.tov[i] = w[tcc_pkg::CB_TOV];
                    d.mx[i]  = w[tcc_pkg::CB_MAX];
                    if (i % 2 == 0) begin
                        d.msb[i] = w[tcc_pkg::CB_MSB];
                    end
                    if (!w[tcc_pkg::CB_FLAG] && q.armed[i]) begin
                        d.flag[i] = 1'b0;
                    end
                    d.armed[i] = 1'b0;
                end
                if (hit_h[i]) begin
                    d.val[i][15:8] = w;
                    if (msnz[i]) begin
                        d.cmp_lock[i] = 1'b1;
                    end
                end
                if (hit_l[i]) begin
                    d.val[i][7:0]  = w;
                    d.cmp_lock[i]  = 1'b0;
                end
            end
            if (hit_t) begin
                d.counter_stop_bit = w[tcc_pkg::TB_STOP];
                d.trst  = w[tcc_pkg::TB_RST];
                d.ps    = w[tcc_pkg::TB_PS +: 3];
            end
            if (hit_m) begin
                d.modulo = PWDATA_IN[15:0];
            end
        end

        // read side effects, taken at the completing edge
        if (r_en) begin
            for (int i = 0; i < tcc_pkg::NCH; i++) begin
                if (hit_c[i] && q.rdata[tcc_pkg::CB_FLAG]) begin
                    d.armed[i] = 1'b1;
                end
                if (hit_h[i] && !msnz[i]) begin
                    d.cap_lock[i] = 1'b1;
                end
                if (hit_l[i]) begin
                    d.cap_lock[i] = 1'b0;
                end
            end
        end

        // pin synchronisers and channel engines
        d.s1   = CH_PIN_IN;
        d.s2   = q.s1;
        d.prev = q.s2;
        for (int i = 0; i < tcc_pkg::NCH; i++) begin
            src = i;
            if (bufm[i] && q.bsel[i >> 1]) begin
                src = i + 1;
            end
            ev_cap[i] = capm[i] && !q.cap_lock[i]
                        && ((q.els[i][0] && q.s2[i] && !q.prev[i])
                        || (q.els[i][1] && !q.s2[i] && q.prev[i]));
            match[i]  = cmpm[i] && cstep && !q.cmp_lock[src]
                        && (ccnt == q.val[src]);
            ev[i]     = ev_cap[i] | match[i];
            if (ev_cap[i]) begin
                d.val[i] = ccnt;
            end
            if (ev[i]) begin
                d.flag[i]  = 1'b1;
                d.armed[i] = 1'b0;
            end
            if (covf || !cmpm[i]) begin
                d.mx_eff[i] = q.mx[i];
            end
            if (bufm[i] && act[i] && covf) begin
                d.bsel[i >> 1] = ~q.bsel[i >> 1];
            end
            if (!act[i]) begin
                d.oe[i]  = 1'b0;
                d.out[i] = ~q.msa[i];
            end else if (capm[i]) begin
                d.oe[i]  = 1'b0;
            end else begin
                d.oe[i] = 1'b1;
                if (q.tov[i] && covf) begin
                    d.out[i] = ~q.out[i];
                end else if (match[i]) begin
                    unique case (q.els[i])
                        tcc_pkg::ELS_TOGGLE: d.out[i] = ~q.out[i];
                        tcc_pkg::ELS_LOW:    d.out[i] = 1'b0;
                        tcc_pkg::ELS_HIGH:   d.out[i] = 1'b1;
                        default:             d.out[i] = q.out[i];
                    endcase
                end
                if (!q.tov[i] && d.mx_eff[i]) begin
                    d.out[i] = 1'b1;
                end
            end
        end
        d.irq = d.flag & d.ie;
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            q        <= '0;
            q.counter_stop_bit  <= tcc_pkg::STOP_RST;
            q.modulo <= tcc_pkg::MOD_RST;
            q.ps     <= tcc_pkg::PS_RST;
        end else begin
            q <= d;
        end
    end

    assign PRDATA_OUT    = q.rdata;
    assign PREADY_OUT    = q.ready;
    assign PSLVERR_OUT   = q.slverr;
    assign CH_PIN_OUT    = q.out;
    assign CH_PIN_OE_OUT = q.oe;
    assign CH_IRQ_OUT    = q.irq;
endmodule : tcc_timer_channels

// ### dv/tcc_timer_channels_assertions.sv
// port assertions for the timer channel block
`timescale 1ns/100ps
module tcc_timer_channels_chk (
    input wire logic        MCLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic [3:0]  CH_PIN_IN,
    input wire logic [3:0]  CH_PIN_OUT,
    input wire logic [3:0]  CH_PIN_OE_OUT,
    input wire logic [3:0]  CH_IRQ_OUT
);
    logic wr_done;
    assign wr_done = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence s_setup;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence s_access;
        PSEL_IN && PENABLE_IN;
    endsequence
    chk_ready_answer: assert property (s_setup ##1 s_access |=> PREADY_OUT)
        else $error("no ready after access phase");
    chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    chk_data_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data outside ready");
    chk_irq_reset: assert property ($fell(SYS_RST_IN) |-> CH_IRQ_OUT == 4'h0)
        else $error("irq set after reset");
    chk_oe_reset: assert property ($fell(SYS_RST_IN) |-> CH_PIN_OE_OUT == 4'h0)
        else $error("pin driven after reset");
    chk_irq_fall_write: assert property (|($past(CH_IRQ_OUT) & ~CH_IRQ_OUT) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("irq dropped without write");
    chk_oe_by_write: assert property ($changed(CH_PIN_OE_OUT) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("pin enable changed without write");
    cover property (|CH_IRQ_OUT);
endmodule : tcc_timer_channels_chk
bind tcc_timer_channels tcc_timer_channels_chk i_chk (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .CH_PIN_IN(CH_PIN_IN), .CH_PIN_OUT(CH_PIN_OUT), .CH_PIN_OE_OUT(CH_PIN_OE_OUT), .CH_IRQ_OUT(CH_IRQ_OUT));

// ### dv/tcc_pin_board.sv
// board model of the four channel pins
`timescale 1ns/100ps
module tcc_pin_board (
    input  wire logic       clk_in,
    input  wire logic [3:0] drv_in,
    input  wire logic [3:0] pin_out_in,
    input  wire logic [3:0] pin_oe_in,
    output logic      [3:0] pin_lvl_out
);
    // board level changes once per clock, held at least a clock
    always_ff @(posedge clk_in) begin
        pin_lvl_out <= (pin_oe_in & pin_out_in) | (~pin_oe_in & drv_in);
    end
endmodule : tcc_pin_board

// ### dv/tcc_timer_channels_test.sv
// testbench of the timer channel block
`timescale 1ns/100ps
module tcc_timer_channels_test;
    logic        clk = 1'h0;
    logic        rst, psel, pen, pwr, pready, perr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pin_in, pin_out, pin_oe, irq, drv;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    tcc_timer_channels i_dut (.MCLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(perr), .CH_PIN_IN(pin_in), .CH_PIN_OUT(pin_out), .CH_PIN_OE_OUT(pin_oe), .CH_IRQ_OUT(irq));
    tcc_pin_board i_board (.clk_in(clk), .drv_in(drv), .pin_out_in(pin_out), .pin_oe_in(pin_oe),
        .pin_lvl_out(pin_in));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        r = prdata;
        e = perr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr
    task rd(input string n, input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(n, x, r);
    endtask : rd
    function logic [7:0] ctl(input int n);
        return tcc_pkg::OFF_CTRL0 + 8'(tcc_pkg::REG_STRIDE * n);
    endfunction : ctl
    task pin0(input logic v, input int n);
        drv[0] <= v;
        repeat (n) @(posedge clk);
    endtask : pin0
    task t_reset();
        for (int i = 0; i < 4; i++) rd("ctrl", ctl(i), 32'h0);
        chk("oe", 32'h0, 32'(pin_oe));
        chk("pin", 32'hf, 32'(pin_out));
        apb(1'h0, 8'hfc, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        wr(tcc_pkg::OFF_TCTL, 32'h30);
        rd("cnt", tcc_pkg::OFF_CNT, 32'h0);
    endtask : t_reset
    task t_preset();
        wr(ctl(2), 32'h10);
        pin0(1'h0, 2);
        chk("preset lo", 32'h0, 32'(pin_out[2]));
        chk("preset oe", 32'h0, 32'(pin_oe[2]));
        wr(ctl(2), 32'h0);
        pin0(1'h0, 2);
        chk("preset hi", 32'h1, 32'(pin_out[2]));
    endtask : t_preset
    task t_capture();
        logic [31:0] cv;
        for (int c = 1; c < 4; c++) begin
            cv = 32'h40 | (32'(c) << 2);
            wr(ctl(0), cv);
            pin0(1'h1, 6);
            chk("irq rise", 32'(c & 1), 32'(irq[0]));
            rd("flag rise", ctl(0), cv | (32'(c & 1) << 7));
            wr(ctl(0), cv);
            pin0(1'h0, 6);
            chk("irq fall", 32'(c >> 1), 32'(irq[0]));
            rd("flag fall", ctl(0), cv | (32'(c >> 1) << 7));
            wr(ctl(0), cv);
            chk("irq clr", 32'h0, 32'(irq[0]));
        end
        wr(tcc_pkg::OFF_VALH0, 32'haa);
        pin0(1'h1, 6);
        rd("val hi", tcc_pkg::OFF_VALH0, 32'h0);
        rd("val lo", tcc_pkg::OFF_VALL0, 32'h0);
        wr(ctl(0), 32'h4c);
        chk("zero no read", 32'h1, 32'(irq[0]));
        wr(ctl(0), 32'hcc);
        chk("write one", 32'h1, 32'(irq[0]));
        wr(ctl(0), 32'h0c);
        pin0(1'h1, 2);
        chk("irq masked", 32'h0, 32'(irq[0]));
        rd("flag kept", ctl(0), 32'h8c);
        wr(ctl(0), 32'h0c);
        rd("flag clr", ctl(0), 32'h0c);
        wr(ctl(0), 32'h0);
    endtask : t_capture
    task t_compare();
        int n;
        wr(tcc_pkg::OFF_MOD, 32'h9);
        wr(tcc_pkg::OFF_VALH0 + 8'h4, 32'h0);
        wr(tcc_pkg::OFF_VALL0 + 8'h4, 32'h5);
        for (int c = 1; c < 4; c++) begin
            wr(ctl(1), (c == 2) ? 32'h0 : 32'h10);
            wr(ctl(1), 32'h50 | (32'(c) << 2));
            wr(tcc_pkg::OFF_TCTL, 32'h0);
            n = 0;
            while (irq[1] !== 1'h1 && n < 100) begin
                @(posedge clk);
                n++;
            end
            chk("cmp irq", 32'h1, 32'(irq[1]));
            pin0(1'h1, 2);
            chk("cmp pin", 32'(c != 2), 32'(pin_out[1]));
            chk("cmp oe", 32'h1, 32'(pin_oe[1]));
            wr(tcc_pkg::OFF_TCTL, 32'h30);
            rd("cmp flag", ctl(1), 32'hd0 | (32'(c) << 2));
            wr(ctl(1), 32'h10);
        end
    endtask : t_compare
    task t_buffer();
        wr(ctl(1), 32'h54);
        wr(ctl(0), 32'h24);
        pin0(1'h1, 2);
        chk("odd oe", 32'h0, 32'(pin_oe[1]));
        chk("even oe", 32'h1, 32'(pin_oe[0]));
        rd("odd ctrl", ctl(1), 32'h0);
        wr(ctl(1), 32'h5c);
        rd("odd ctrl wr", ctl(1), 32'h0);
        wr(ctl(0), 32'h0);
    endtask : t_buffer
    initial begin
        rst = 1'h1;
        psel = 1'h0;
        pen = 1'h0;
        pwr = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        drv = 4'h0;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_preset();
        t_capture();
        t_compare();
        t_buffer();
        finish_test();
    end
endmodule : tcc_timer_channels_test
